// ==== src/ecf_pkg.sv ====
// Package: register map, field layout, reset values and response codes
// of the encoder channel error flag block.
// Assumes a 32-bit AXI4-Lite register bus and a 25 MHz single clock.
package ecf_pkg;

	// ========================================================
	// Bus and clock
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          CLK_PERIOD_NS = 40;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ========================================================
	// Register byte offsets
	localparam logic [7:0]  OFS_ASIC_STATUS = 8'h00;
	localparam logic [7:0]  OFS_CMD         = 8'h04;
	localparam logic [7:0]  OFS_CFG         = 8'h08;
	localparam logic [7:0]  OFS_VEC_MIN     = 8'h0C;
	localparam logic [7:0]  OFS_SPEED_THR   = 8'h10;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h14;
	localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h18;
	localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h1C;
	localparam logic [7:0]  OFS_PRESET1     = 8'h20;
	localparam logic [7:0]  OFS_PRESET2     = 8'h24;
	localparam logic [7:0]  OFS_COUNT1      = 8'h28;
	localparam logic [7:0]  OFS_COUNT2      = 8'h2C;

	// ========================================================
	// Field positions
	localparam int CMD_RESET_COUNTER_BIT = 0;
	localparam int CFG_COUNTER_MODE_BIT  = 0;
	localparam int CFG_RATE_LSB          = 4;
	localparam int CFG_RATE_W            = 4;
	localparam int CFG_MIN_EDGE_LSB      = 16;
	localparam int CFG_MIN_EDGE_W        = 16;
	localparam int THR_COUNTER_LSB       = 0;
	localparam int THR_SQUARE_LSB        = 16;
	localparam int THR_W                 = 16;

	// Flag position inside one channel's group
	localparam int FLG_VECTOR_SMALL  = 0;
	localparam int FLG_COS_CONV_OVER = 1;
	localparam int FLG_SIN_CONV_OVER = 2;
	localparam int FLG_OVERSPEED     = 3;
	localparam int FLG_SQUARE_INVAL  = 4;
	localparam int FLG_COS_GAIN_LIM  = 5;
	localparam int FLG_SIN_GAIN_LIM  = 6;
	localparam int FLG_COS_OFS_LIM   = 7;
	localparam int FLG_SIN_OFS_LIM   = 8;
	localparam int FLAGS_PER_CH      = 9;
	localparam int NUM_CH            = 2;
	localparam int FLAG_W            = FLAGS_PER_CH * NUM_CH;

	// ========================================================
	// Reset values
	localparam logic [31:0] CFG_RST       = 32'h0004_0000;
	localparam logic [31:0] VEC_MIN_RST   = 32'h0000_1000;
	localparam logic [31:0] SPEED_THR_RST = 32'h0002_0001;
	localparam logic [31:0] PRESET_RST    = 32'h0000_0000;

endpackage

// ==== src/ecf_if.sv ====
// Interfaces between the block's own modules: the register access port
// behind the bus slave, and the edge timing monitor of one channel.
// Assumes every signal is on aclk.

// ========================================================
// Register access
interface ecf_reg_if;
	logic        wr_en;
	logic [7:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wr_err;
	logic [7:0]  raddr;
	logic [31:0] rdata;
	logic        rd_err;
	modport slave (output wr_en, waddr, wdata, wstrb, raddr,
		input wr_err, rdata, rd_err);
	modport regs (input wr_en, waddr, wdata, wstrb, raddr,
		output wr_err, rdata, rd_err);
endinterface

// ========================================================
// Edge timing of one channel
interface ecf_chan_if;
	logic        edge_pulse;
	logic        counter_mode;
	logic [15:0] min_edge;
	logic [15:0] fast_thr;
	logic        too_fast_sq;
	logic        overspeed;
	modport mon (input edge_pulse, counter_mode, min_edge, fast_thr,
		output too_fast_sq, overspeed);
	modport host (output edge_pulse, counter_mode, min_edge, fast_thr,
		input too_fast_sq, overspeed);
endinterface

// ==== src/ecf_axil_slave.sv ====
// AXI4-Lite slave: one write and one read in flight, no wait on reads.
// Assumes the register side answers read data combinationally.
module ecf_axil_slave
	import ecf_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	ecf_reg_if.slave               rif
);
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;

	// ========================================================
	// Write channels
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign rif.wr_en     = aw_got_q && w_got_q;
	assign rif.waddr     = awaddr_q;
	assign rif.wdata     = wdata_q;
	assign rif.wstrb     = wstrb_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (rif.wr_en) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (rif.wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ========================================================
	// Read channels
	assign s_axi_arready = !s_axi_rvalid;
	assign rif.raddr     = s_axi_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rif.rdata;
			s_axi_rresp  <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ==== src/ecf_edge_mon.sv ====
// Edge interval monitor for one channel: flags edges that come too close.
// Assumes edge_pulse is a one-cycle strobe on aclk.
module ecf_edge_mon
	import ecf_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	ecf_chan_if.mon   cif
);
	logic [15:0] gap_q;

	// Starts saturated so the first edge never looks fast
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_q <= 16'hFFFF;
		end else if (cif.edge_pulse) begin
			gap_q <= 16'h0000;
		end else if (gap_q != 16'hFFFF) begin
			gap_q <= gap_q + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cif.too_fast_sq <= 1'b0;
			cif.overspeed   <= 1'b0;
		end else begin
			cif.too_fast_sq <= cif.edge_pulse && !cif.counter_mode &&
				(gap_q < cif.min_edge);
			cif.overspeed   <= cif.edge_pulse &&
				(gap_q < cif.fast_thr);
		end
	end
endmodule

// ==== src/ecf_top.sv ====
// Top: per-channel error flags of a two-channel sine/cosine interpolator,
// position counters and interrupt, behind an AXI4-Lite register slave.
// Assumes samples, edges and controller limits are on aclk; converter
// overdrive arrives from the analog side and is synchronised here.
//
// Functional notes
// - Channel 2 square-out invalid (bit 13) on edges closer than min interval.
// - Channel 1 square-out invalid (bit 4) under the same check.
// - Changing interpolation rate or min edge interval raises square-invalid.
// - Counter mode disables square-out invalid detection entirely.
// - Overspeed flag (bits 12 and 3) when edges come too fast.
// - Overspeed threshold differs between counter mode and square-out mode.
// - Sine converter overdrive sets bit 11 or bit 2.
// - Cosine converter overdrive sets bit 10 or bit 1.
// - Vector magnitude below minimum sets bit 9 or bit 0.
// - Channel 1 sine offset controller at limit sets bit 8.
// - Channel 1 cosine offset controller at limit sets bit 7.
// - Channel 1 sine gain controller at limit sets bit 6.
// - Cosine gain controller at limit sets bit 5 or bit 14.
// - Flags reset to zero and stay zero while no error seen.
// - Reset-counter command clears the asic_status flags (not the IRQ status) and loads counters from presets.
//
// The address map and register access over AXI4-Lite were left to the implementer.
module ecf_top
	import ecf_pkg::*;
#(
	parameter int SAMPLE_W = 12,
	parameter int COUNT_W  = 32
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [NUM_CH-1:0]          sample_valid,
	input  wire logic [NUM_CH*SAMPLE_W-1:0] sine_sample,
	input  wire logic [NUM_CH*SAMPLE_W-1:0] cosine_sample,
	input  wire logic [NUM_CH-1:0]          quad_edge,
	input  wire logic [NUM_CH-1:0]          quad_dir_up,
	input  wire logic [NUM_CH-1:0]          sine_conv_overdrive_pin,
	input  wire logic [NUM_CH-1:0]          cosine_conv_overdrive_pin,
	input  wire logic [NUM_CH-1:0]          sine_offset_at_limit,
	input  wire logic [NUM_CH-1:0]          cosine_offset_at_limit,
	input  wire logic [NUM_CH-1:0]          sine_gain_at_limit,
	input  wire logic [NUM_CH-1:0]          cosine_gain_at_limit,
	output logic                            irq
);
	localparam int MAG_W = 2 * SAMPLE_W + 1;

	// ========================================================
	// Helpers
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Unaligned or past the map answers SLVERR
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= OFS_COUNT2);
	endfunction

	// Status bit: channel group base plus position
	function automatic int flag_pos(input int ch, input int pos);
		return ch * FLAGS_PER_CH + pos;
	endfunction

	// ========================================================
	// Register bus
	ecf_reg_if rif ();

	ecf_axil_slave u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.rif           (rif.slave)
	);

	logic [31:0]        cfg_q;
	logic [31:0]        vec_min_q;
	logic [31:0]        speed_thr_q;
	logic [FLAG_W-1:0]  irq_enable_q;
	logic [FLAG_W-1:0]  irq_status_q;
	logic [FLAG_W-1:0]  asic_status_q;
	logic [31:0]        preset_q [NUM_CH];
	logic [COUNT_W-1:0] count_q [NUM_CH];
	logic [FLAG_W-1:0]  evt;
	logic               wr_cmd;
	logic               wr_cfg;
	logic               wr_irq_clear;
	logic               reset_counter_cmd;
	logic               cfg_change;
	logic [31:0]        cfg_d;
	logic [31:0]        wr_word;
	logic [31:0]        irq_en_word;

	assign wr_cmd       = rif.wr_en && (rif.waddr == OFS_CMD);
	assign wr_cfg       = rif.wr_en && (rif.waddr == OFS_CFG);
	assign wr_irq_clear = rif.wr_en && (rif.waddr == OFS_IRQ_CLEAR);
	assign wr_word      = merge_strb(32'h0000_0000, rif.wdata, rif.wstrb);
	assign irq_en_word  = merge_strb({{(32-FLAG_W){1'b0}}, irq_enable_q},
		rif.wdata, rif.wstrb);
	assign reset_counter_cmd = wr_cmd && wr_word[CMD_RESET_COUNTER_BIT];
	assign cfg_d        = merge_strb(cfg_q, rif.wdata, rif.wstrb);
	// Any real change of rate or interval disturbs the square outputs
	assign cfg_change   = wr_cfg &&
		((cfg_d[CFG_RATE_LSB +: CFG_RATE_W] !=
		cfg_q[CFG_RATE_LSB +: CFG_RATE_W]) ||
		(cfg_d[CFG_MIN_EDGE_LSB +: CFG_MIN_EDGE_W] !=
		cfg_q[CFG_MIN_EDGE_LSB +: CFG_MIN_EDGE_W]));
	assign rif.wr_err   = !is_mapped(rif.waddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q        <= CFG_RST;
			vec_min_q    <= VEC_MIN_RST;
			speed_thr_q  <= SPEED_THR_RST;
			irq_enable_q <= '0;
		end else if (rif.wr_en) begin
			unique case (rif.waddr)
				OFS_CFG:        cfg_q <= cfg_d;
				OFS_VEC_MIN:    vec_min_q <=
					merge_strb(vec_min_q, rif.wdata, rif.wstrb);
				OFS_SPEED_THR:  speed_thr_q <=
					merge_strb(speed_thr_q, rif.wdata, rif.wstrb);
				// Flag bits only; the rest read zero
				OFS_IRQ_ENABLE: irq_enable_q <= irq_en_word[FLAG_W-1:0];
				// Read-only and unmapped words are ignored
				default: ;
			endcase
		end
	end

	// ========================================================
	// Read decode
	// Write-only words read as zero
	always_comb begin
		rif.rdata  = 32'h0000_0000;
		rif.rd_err = !is_mapped(rif.raddr);
		unique case (rif.raddr)
			OFS_ASIC_STATUS: rif.rdata[FLAG_W-1:0] = asic_status_q;
			OFS_CFG:         rif.rdata = cfg_q;
			OFS_VEC_MIN:     rif.rdata = vec_min_q;
			OFS_SPEED_THR:   rif.rdata = speed_thr_q;
			OFS_IRQ_STATUS:  rif.rdata[FLAG_W-1:0] = irq_status_q;
			OFS_IRQ_ENABLE:  rif.rdata[FLAG_W-1:0] = irq_enable_q;
			OFS_PRESET1:     rif.rdata = preset_q[0];
			OFS_PRESET2:     rif.rdata = preset_q[1];
			OFS_COUNT1:      rif.rdata = 32'(count_q[0]);
			OFS_COUNT2:      rif.rdata = 32'(count_q[1]);
			default: ;
		endcase
	end

	// ========================================================
	// Analog-side overdrive synchronisers
	// Only the second stage feeds logic
	logic [2*NUM_CH-1:0] over_meta_q;
	logic [2*NUM_CH-1:0] over_sync_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			over_meta_q <= '0;
			over_sync_q <= '0;
		end else begin
			over_meta_q <= {cosine_conv_overdrive_pin, sine_conv_overdrive_pin};
			over_sync_q <= over_meta_q;
		end
	end

	// ========================================================
	// Per-channel event detection and counters
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		ecf_chan_if                  cif ();
		logic signed [SAMPLE_W-1:0]  s_smp;
		logic signed [SAMPLE_W-1:0]  c_smp;
		logic signed [MAG_W-2:0]     s_sq;
		logic signed [MAG_W-2:0]     c_sq;
		logic [MAG_W-1:0]            mag2;

		assign cif.edge_pulse   = quad_edge[c];
		assign cif.counter_mode = cfg_q[CFG_COUNTER_MODE_BIT];
		assign cif.min_edge     = cfg_q[CFG_MIN_EDGE_LSB +: CFG_MIN_EDGE_W];
		// Counter mode tolerates faster edges than the square outputs
		assign cif.fast_thr     = cfg_q[CFG_COUNTER_MODE_BIT] ?
			speed_thr_q[THR_COUNTER_LSB +: THR_W] :
			speed_thr_q[THR_SQUARE_LSB +: THR_W];

		ecf_edge_mon u_mon (
			.aclk    (aclk),
			.aresetn (aresetn),
			.cif     (cif.mon)
		);

		assign s_smp = sine_sample[c*SAMPLE_W +: SAMPLE_W];
		assign c_smp = cosine_sample[c*SAMPLE_W +: SAMPLE_W];
		// Squares at full width; a sample-wide product would wrap
		assign s_sq  = s_smp * s_smp;
		assign c_sq  = c_smp * c_smp;
		assign mag2  = MAG_W'(unsigned'(s_sq)) +
			MAG_W'(unsigned'(c_sq));

		assign evt[flag_pos(c, FLG_VECTOR_SMALL)]  = sample_valid[c] &&
			(mag2 < MAG_W'(vec_min_q));
		assign evt[flag_pos(c, FLG_COS_CONV_OVER)] =
			over_sync_q[NUM_CH + c];
		assign evt[flag_pos(c, FLG_SIN_CONV_OVER)] = over_sync_q[c];
		assign evt[flag_pos(c, FLG_OVERSPEED)]     = cif.overspeed;
		assign evt[flag_pos(c, FLG_SQUARE_INVAL)]  = cif.too_fast_sq ||
			(cfg_change && !cfg_q[CFG_COUNTER_MODE_BIT]);
		assign evt[flag_pos(c, FLG_COS_GAIN_LIM)]  =
			cosine_gain_at_limit[c];
		assign evt[flag_pos(c, FLG_SIN_GAIN_LIM)]  =
			sine_gain_at_limit[c];
		assign evt[flag_pos(c, FLG_COS_OFS_LIM)]   =
			cosine_offset_at_limit[c];
		assign evt[flag_pos(c, FLG_SIN_OFS_LIM)]   =
			sine_offset_at_limit[c];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				preset_q[c] <= PRESET_RST;
			end else if (rif.wr_en &&
				(rif.waddr == (c == 0 ? OFS_PRESET1 : OFS_PRESET2))) begin
				preset_q[c] <= merge_strb(preset_q[c], rif.wdata, rif.wstrb);
			end
		end

		// Reload beats a coincident edge
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				count_q[c] <= '0;
			end else if (reset_counter_cmd) begin
				count_q[c] <= COUNT_W'(preset_q[c]);
			end else if (quad_edge[c]) begin
				count_q[c] <= quad_dir_up[c] ? count_q[c] + 1'b1 :
					count_q[c] - 1'b1;
			end
		end
	end

	// ========================================================
	// Sticky flags; a new event beats the clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asic_status_q <= '0;
		end else if (reset_counter_cmd) begin
			asic_status_q <= evt;
		end else begin
			asic_status_q <= asic_status_q | evt;
		end
	end

	// Kept apart from asic_status; own clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= '0;
		end else if (wr_irq_clear) begin
			irq_status_q <= (irq_status_q & ~wr_word[FLAG_W-1:0]) | evt;
		end else begin
			irq_status_q <= irq_status_q | evt;
		end
	end

	// Level output, high while an enabled bit is set
	assign irq = |(irq_status_q & irq_enable_q);
endmodule

// ==== dv/ecf_top_assertions.sv ====
// Checker: bus timing and interrupt relations at the ecf_top ports.
// Assumes it is bound into ecf_top and sees its ports only.
module ecf_top_assertions
	import ecf_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ====
	// Bus
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_block: assert property (p_b_block) else $error("write taken early");
	property p_r_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_block: assert property (p_r_block) else $error("read taken early");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2C
			|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
	property p_mapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h2C
			&& s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == RESP_OKAY;
	endproperty
	a_mapped: assert property (p_mapped) else $error("bad mapped response");

	// ====
	// Interrupt
	property p_irq_rst;
		$rose(aresetn) |-> !irq;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
	// Only a register write may take the sticky interrupt down
	property p_irq_sticky;
		$fell(irq) |-> s_axi_bvalid;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("irq lost");
	c_write: cover property (s_axi_bvalid);
	c_unmapped: cover property (s_axi_arvalid && s_axi_araddr > 8'h2C);
	c_irq: cover property ($rose(irq));
endmodule

bind ecf_top ecf_top_assertions i_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq
);

// ==== dv/ecf_sensor_model.sv ====
// Partner model: two sine/cosine sensor channels with limit levels.
// Assumes its tasks are called just after a rising aclk edge.
module ecf_sensor_model
	import ecf_pkg::*;
(
	input  wire logic       aclk,
	output logic [1:0]      sample_valid,
	output logic [23:0]     sine_sample,
	output logic [23:0]     cosine_sample,
	output logic [1:0]      quad_edge,
	output logic [1:0]      quad_dir_up,
	output logic [5:0][1:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sample_valid = '0;
		sine_sample = '0;
		cosine_sample = '0;
		quad_edge = '0;
		quad_dir_up = '1;
		lvl = '0;
	end
	// Spacing is in cycles from one edge to the next
	task automatic edges(input int c, input int gap, input int n);
		for (int i = 0; i < n; i++) begin
			quad_edge[c] <= 1'b1;
			@(posedge aclk);
			if (gap > 1 || i == n - 1) quad_edge[c] <= 1'b0;
			repeat (gap - 1) @(posedge aclk);
		end
	endtask
	// Invalid samples show the inverse so stale data never looks good
	task automatic vec(input int c, input logic [11:0] s,
		input logic [11:0] k);
		sample_valid[c] <= 1'b1;
		sine_sample[c*12 +: 12] <= s;
		cosine_sample[c*12 +: 12] <= k;
		@(posedge aclk);
		sample_valid[c] <= 1'b0;
		sine_sample[c*12 +: 12] <= ~s;
		cosine_sample[c*12 +: 12] <= ~k;
	endtask
	task automatic pulse(input int k, input int c);
		lvl[k][c] <= 1'b1;
		repeat (2) @(posedge aclk);
		lvl[k][c] <= 1'b0;
	endtask
endmodule

// ==== dv/tb.sv ====
// Bench: ecf_top over AXI4-Lite with the sensor model on the far side.
// Assumes a 25 MHz clock and a synchronous active-low reset.
module tb
	import ecf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   aclk, aresetn, irq;
	logic [ADDR_W-1:0]      s_axi_awaddr, s_axi_araddr;
	logic [31:0]            s_axi_wdata, s_axi_rdata;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                   s_axi_rready;
	logic [1:0]             sample_valid, quad_edge, quad_dir_up;
	logic [23:0]            sine_sample, cosine_sample;
	logic [5:0][1:0]        lvl;
	int                     mismatches, num_checks;

	ecf_top i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sample_valid, .sine_sample,
		.cosine_sample, .quad_edge, .quad_dir_up, .irq,
		.sine_offset_at_limit(lvl[0]), .cosine_offset_at_limit(lvl[1]),
		.sine_gain_at_limit(lvl[2]), .cosine_gain_at_limit(lvl[3]),
		.sine_conv_overdrive_pin(lvl[4]), .cosine_conv_overdrive_pin(lvl[5])
	);
	ecf_sensor_model i_sens (
		.aclk, .sample_valid, .sine_sample, .cosine_sample, .quad_edge,
		.quad_dir_up, .lvl
	);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// ====
	// Bus and compare tasks
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		mismatches++;
		$display("Error %0t: bus gave no answer", $time);
		conclude();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n > 50) hang();
		end while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(RESP_OKAY));
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		int n = 0;
		repeat (4) @(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 50) hang();
		end while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic clr();
		wr(OFS_CMD, 32'h1 << CMD_RESET_COUNTER_BIT);
		rc(OFS_ASIC_STATUS, 32'h0);
	endtask

	// ====
	// Scenarios
	task automatic t_reset();
		rc(OFS_ASIC_STATUS, 32'h0);
		rc(OFS_CFG, CFG_RST);
		rc(OFS_SPEED_THR, SPEED_THR_RST);
		rc(8'h30, 32'h0, RESP_SLVERR);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_flags();
		int fl[6] = '{FLG_SIN_OFS_LIM, FLG_COS_OFS_LIM, FLG_SIN_GAIN_LIM,
			FLG_COS_GAIN_LIM, FLG_SIN_CONV_OVER, FLG_COS_CONV_OVER};
		for (int c = 0; c < NUM_CH; c++) begin
			for (int k = 0; k < 6; k++) begin
				i_sens.pulse(k, c);
				rc(OFS_ASIC_STATUS, 32'h1 << (c * 9 + fl[k]));
				clr();
			end
		end
	endtask
	task automatic t_vector();
		for (int c = 0; c < NUM_CH; c++) begin
			i_sens.vec(c, 12'h040, 12'h000);
			rc(OFS_ASIC_STATUS, 32'h0);
			i_sens.vec(c, 12'h03F, 12'h000);
			rc(OFS_ASIC_STATUS, 32'h1 << (c * 9 + FLG_VECTOR_SMALL));
			clr();
		end
	endtask
	task automatic t_speed();
		logic [31:0] both;
		both = 32'h1 << FLG_SQUARE_INVAL | 32'h1 << (9 + FLG_SQUARE_INVAL);
		for (int c = 0; c < NUM_CH; c++) begin
			i_sens.edges(c, 5, 3);
			rc(OFS_ASIC_STATUS, 32'h0);
			i_sens.edges(c, 4, 3);
			rc(OFS_ASIC_STATUS, 32'h1 << (c * 9 + FLG_SQUARE_INVAL));
			clr();
			i_sens.edges(c, 2, 3);
			rc(OFS_ASIC_STATUS, 32'h3 << (c * 9 + FLG_OVERSPEED));
			clr();
		end
		wr(OFS_CFG, CFG_RST | 32'h1);
		i_sens.edges(0, 2, 3);
		rc(OFS_ASIC_STATUS, 32'h0);
		i_sens.edges(0, 1, 3);
		rc(OFS_ASIC_STATUS, 32'h1 << FLG_OVERSPEED);
		wr(OFS_CFG, CFG_RST);
		clr();
		wr(OFS_CFG, 32'h0005_0000);
		rc(OFS_ASIC_STATUS, both);
		clr();
		wr(OFS_CFG, 32'h0005_0010);
		rc(OFS_ASIC_STATUS, both);
		wr(OFS_CFG, CFG_RST);
		wr(OFS_PRESET1, 32'h0000_0025);
		wr(OFS_PRESET2, 32'h0000_0007);
		clr();
		rc(OFS_COUNT1, 32'h0000_0025);
		rc(OFS_COUNT2, 32'h0000_0007);
	endtask
	task automatic t_irq();
		wr(OFS_IRQ_CLEAR, 32'hFFFF_FFFF);
		i_sens.pulse(3, 1);
		rc(OFS_IRQ_STATUS, 32'h0000_4000);
		chk(32'(irq), 32'h0);
		wr(OFS_IRQ_ENABLE, 32'h0000_4000);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h0000_4000);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		rc(OFS_IRQ_STATUS, 32'h0);
		rc(OFS_ASIC_STATUS, 32'h0000_4000);
		clr();
	endtask

	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		mismatches = 0;
		num_checks = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_flags();
		t_vector();
		t_speed();
		t_irq();
		conclude();
	end
endmodule
